// >>> core/asmp_pkg.sv
// Package with constants and types of the async static memory port
package asmp_pkg;
    localparam int          ADDR_W        = 25;
    localparam int          DATA_W        = 16;
    localparam int          SEL_W         = 4;
    localparam int          BE_W          = 2;
    localparam int          CNT_W         = 8;
    // Phase lengths in cycles of clk_sys_i (8 ns)
    localparam logic [7:0]  SETUP_CYC     = 8'h02;
    localparam logic [7:0]  ACCESS_CYC    = 8'h04;
    localparam logic [7:0]  HOLD_CYC      = 8'h01;
    localparam logic [1:0]  BE_ALL        = 2'h0;
    localparam logic [1:0]  BE_NONE       = 2'h3;
    localparam logic [3:0]  SEL_NONE      = 4'hf;
    localparam logic [15:0] DATA_RST      = 16'h0000;
    localparam logic [24:0] ADDR_RST      = 25'h0000000;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_SETUP  = 5'b00010,
        ST_ACCESS = 5'b00100,
        ST_WAIT   = 5'b01000,
        ST_HOLD   = 5'b10000
    } asmp_state_t;
endpackage : asmp_pkg

// >>> core/asmp_sync3.sv
// Three-stage input synchroniser with agreement filter
module asmp_sync3
(
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      level_o
);
    logic [2:0] stage_reg;

    // Stage 0 feeds only stage 1; level moves when stages 1 and 2 agree
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            stage_reg <= 3'h0;
            level_o   <= 1'b0;
        end
        else
        begin
            stage_reg <= {stage_reg[1:0], async_i};
            if (stage_reg[1] == stage_reg[2])
            begin
                level_o <= stage_reg[2];
            end
        end
    end
endmodule : asmp_sync3

// >>> core/asmp_port.sv
// Async static memory port controller
// Behaviour
// RULE1 - Drive the 25-line address bus, bits 0 to 24.
// RULE2 - Upper-byte write: byte lane enable 1 low, enable 0 high.
// RULE3 - Lower-byte write: byte lane enable 1 high, enable 0 low.
// RULE4 - Four active-low memory select outputs, one per memory device.
// RULE5 - Read: output enable strobe asserts from start of setup period.
// RULE6 - Read strobe asserts at the start of each read access.
// RULE7 - Write strobe asserted for the whole access period only.
// RULE8 - Memory ready input holds the access; no new transfer until ready.
// RULE9 - Sixteen-line bidirectional data bus for reads and writes.
// RULE10 - Drive data bus only on writes; release it during reads.
module asmp_port
    import asmp_pkg::*;
(
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    req_valid_i,
    input  wire logic                    req_write_i,
    input  wire logic [asmp_pkg::ADDR_W-1:0] req_addr_i,
    input  wire logic [asmp_pkg::BE_W-1:0]   req_byte_i,
    input  wire logic [asmp_pkg::SEL_W-1:0]  req_sel_i,
    input  wire logic [asmp_pkg::DATA_W-1:0] req_wdata_i,
    output logic                         req_ready_o,
    output logic                         rsp_valid_o,
    output logic [asmp_pkg::DATA_W-1:0]  rsp_rdata_o,
    output logic [asmp_pkg::ADDR_W-1:0]  ext_addr_bus_o,
    output logic [asmp_pkg::BE_W-1:0]    byte_lane_enable_n_o,
    output logic [asmp_pkg::SEL_W-1:0]   mem_select_n_o,
    output logic                         output_enable_strobe_n_o,
    output logic                         read_strobe_n_o,
    output logic                         write_strobe_n_o,
    input  wire logic                    async_ready_in_i,
    input  wire logic [asmp_pkg::DATA_W-1:0] ext_data_bus_i,
    output logic [asmp_pkg::DATA_W-1:0]  ext_data_bus_o,
    output logic                         ext_data_bus_oe_o
);
    import asmp_pkg::*;

    asmp_state_t        state_reg;
    asmp_state_t        state_next;
    logic [CNT_W-1:0]   cnt_reg;
    logic               write_reg;
    logic [DATA_W-1:0]  din_reg;
    logic               ready_sync;

    // Ready is a pin: filtered before it may steer the sequencer
    asmp_sync3 u_ready_sync
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .async_i   (async_ready_in_i),
        .level_o   (ready_sync)
    );

    function automatic logic [BE_W-1:0] lane_code(input logic [BE_W-1:0] bytes);
        // Active-low lanes: upper only gives 01, lower only 10
        lane_code = ~bytes;
    endfunction : lane_code

    wire take_req   = state_reg[0] & req_valid_i;
    wire cnt_done   = (cnt_reg == 8'h01);
    wire access_end = state_reg[2] & cnt_done;
    wire access_go  = access_end & ready_sync;
    // A zero enable mask would write nothing, so it means both lanes
    wire [BE_W-1:0] lanes = (req_byte_i == 2'h0) ? 2'h3 : req_byte_i;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:   if (req_valid_i) state_next = ST_SETUP;
            ST_SETUP:  if (cnt_done) state_next = ST_ACCESS;
            // RULE8 wait on ready
            ST_ACCESS: if (access_end) state_next = ready_sync ? ST_HOLD : ST_WAIT;
            ST_WAIT:   if (ready_sync) state_next = ST_HOLD;
            ST_HOLD:   if (cnt_done) state_next = ST_IDLE;
            default:   state_next = ST_IDLE;
        endcase
    end

    wire wait_go = state_reg[3] & ready_sync;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            if (take_req)
                cnt_reg <= SETUP_CYC;
            else if (state_reg[1] & cnt_done)
                cnt_reg <= ACCESS_CYC;
            else if (access_go | wait_go)
                cnt_reg <= HOLD_CYC;
            else if (cnt_reg != 8'h00)
                cnt_reg <= cnt_reg - 8'h01;
        end
    end

    // Strobe levels for the next cycle, so outputs come straight from flops
    wire rd_next = ~write_reg;
    wire in_setup_n  = (state_next == ST_SETUP);
    wire in_access_n = (state_next == ST_ACCESS) | (state_next == ST_WAIT);
    wire busy_n      = (state_next != ST_IDLE);
    wire rd_pend     = take_req ? ~req_write_i : rd_next;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            write_reg                <= 1'b0;
            ext_addr_bus_o           <= ADDR_RST;
            byte_lane_enable_n_o     <= BE_NONE;
            mem_select_n_o           <= SEL_NONE;
            output_enable_strobe_n_o <= 1'b1;
            read_strobe_n_o          <= 1'b1;
            write_strobe_n_o         <= 1'b1;
            ext_data_bus_o           <= DATA_RST;
            ext_data_bus_oe_o        <= 1'b0;
            req_ready_o              <= 1'b0;
            rsp_valid_o              <= 1'b0;
            rsp_rdata_o              <= DATA_RST;
            din_reg                  <= DATA_RST;
        end
        else
        begin
            req_ready_o <= (state_next == ST_IDLE) & ~take_req;
            rsp_valid_o <= state_reg[4] & cnt_done;
            din_reg     <= ext_data_bus_i;
            if (take_req)
            begin
                write_reg            <= req_write_i;
                // RULE1 latch address
                ext_addr_bus_o       <= req_addr_i;
                // RULE2 RULE3 lane enables
                byte_lane_enable_n_o <= req_write_i ? lane_code(lanes) : BE_ALL;
                // RULE4 select every device whose req_sel_i bit is set
                mem_select_n_o       <= ~req_sel_i;
                ext_data_bus_o       <= req_wdata_i;
            end
            else if (!busy_n)
            begin
                mem_select_n_o       <= SEL_NONE;
                byte_lane_enable_n_o <= BE_NONE;
            end
            // RULE5 oe from setup
            output_enable_strobe_n_o <= ~(rd_pend & (in_setup_n | in_access_n));
            // RULE6 read strobe
            read_strobe_n_o          <= ~(rd_pend & in_access_n);
            // RULE7 write in access only
            write_strobe_n_o         <= ~(~rd_pend & in_access_n);
            // RULE10 drive only writes
            ext_data_bus_oe_o        <= ~rd_pend & busy_n;
            // RULE9 capture read data
            if (access_go | wait_go)
                rsp_rdata_o <= write_reg ? rsp_rdata_o : din_reg;
        end
    end

    // RULE7 strobe only in access
    property p_we_phase;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            !write_strobe_n_o |-> (state_reg[2] | state_reg[3]) && write_reg;
    endproperty
    a_we_phase: assert property (p_we_phase) else $error("write strobe outside access"); // RULE7

    // RULE10 no drive on reads
    property p_no_drive_read;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            !read_strobe_n_o |-> !ext_data_bus_oe_o;
    endproperty
    a_no_drive_read: assert property (p_no_drive_read) else $error("data driven during read"); // RULE10

    // RULE5 oe leads read strobe
    sequence s_oe_setup;
        !output_enable_strobe_n_o && read_strobe_n_o;
    endsequence
    property p_oe_first;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            $fell(read_strobe_n_o) |-> $past(!output_enable_strobe_n_o && read_strobe_n_o);
    endproperty
    a_oe_first: assert property (p_oe_first) else $error("oe did not lead read"); // RULE5

    // RULE5 oe still low when read strobe asserts
    property p_oe_hold;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            s_oe_setup ##1 !read_strobe_n_o |-> !output_enable_strobe_n_o;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("oe dropped during read"); // RULE5

    // RULE8 hold while not ready
    property p_wait_ready;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            state_reg[3] && !ready_sync |=> state_reg[3];
    endproperty
    a_wait_ready: assert property (p_wait_ready) else $error("left wait without ready"); // RULE8

    // RULE6 read strobe with select
    property p_re_sel;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            !read_strobe_n_o |-> mem_select_n_o != SEL_NONE;
    endproperty
    a_re_sel: assert property (p_re_sel) else $error("read without select"); // RULE6

    // RULE2 RULE3 lanes on write
    property p_lanes;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            !write_strobe_n_o |-> byte_lane_enable_n_o != BE_NONE;
    endproperty
    a_lanes: assert property (p_lanes) else $error("write with no byte lane"); // RULE2
endmodule : asmp_port

// >>> tb/asmp_mem_model.sv
// Behavioural memory device facing the port
module asmp_mem_model
(
    input  wire logic        clk_sys_i,
    input  wire logic [3:0]  sel_n_i,
    input  wire logic [2:0]  addr_i,
    input  wire logic [1:0]  lane_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic [15:0] data_i,
    input  wire logic [7:0]  stall_i,
    output logic             ready_o,
    output logic [15:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [8];
    logic [15:0] last_reg = 16'h0000;
    logic [7:0]  cnt_reg = 8'h00;
    logic        act_reg = 1'b0;
    // Busy from select, so ready drops before the three-flop filter samples it
    wire         act = (sel_n_i != 4'hf);
    wire         drive = act && !oe_n_i && we_n_i;
    assign ready_o = (cnt_reg == 8'h00);
    // Released bus toggles so stale data never looks valid
    assign data_o = drive ? mem[addr_i] : ~last_reg;
    always @(posedge clk_sys_i)
    begin
        act_reg <= act;
        last_reg <= data_o;
        if (act && !act_reg)
            cnt_reg <= stall_i;
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
        if (act && !we_n_i && !lane_n_i[1])
            mem[addr_i][15:8] <= data_i[15:8];
        if (act && !we_n_i && !lane_n_i[0])
            mem[addr_i][7:0] <= data_i[7:0];
    end
endmodule : asmp_mem_model

// >>> tb/async_static_memory_port_tb.sv
// Self-checking bench of the static memory port
`define CHK(a, b) tests_run++; if ((a) !== (b)) begin num_errors++; $display("wrong value t=%0t got %h exp %h", $time, a, b); end
module async_static_memory_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import asmp_pkg::*;
    logic clk = 0, rst_n = 0, vld = 0, wr = 0;
    logic [24:0] addr = 0;
    logic [1:0] bsel = 0, lanes_s;
    logic [3:0] sel = 1, sel_s;
    logic [15:0] wd = 0, mem_d, dut_d, rd;
    logic [7:0] stall = 0;
    logic rdy_o, rv, oe_n, re_n, we_n, d_oe, m_rdy, oe_bad;
    logic [24:0] ea, addr_s;
    logic [1:0] be_n;
    logic [3:0] ms_n;
    int num_errors = 0, tests_run = 0, cnt;
    wire [15:0] bus = d_oe ? dut_d : mem_d;
    initial forever #4 clk = ~clk;
    asmp_port DUT (.clk_sys_i(clk), .rst_n_i(rst_n), .req_valid_i(vld), .req_write_i(wr),
        .req_addr_i(addr), .req_byte_i(bsel), .req_sel_i(sel), .req_wdata_i(wd),
        .req_ready_o(rdy_o), .rsp_valid_o(rv), .rsp_rdata_o(rd), .ext_addr_bus_o(ea),
        .byte_lane_enable_n_o(be_n), .mem_select_n_o(ms_n), .output_enable_strobe_n_o(oe_n),
        .read_strobe_n_o(re_n), .write_strobe_n_o(we_n), .async_ready_in_i(m_rdy),
        .ext_data_bus_i(bus), .ext_data_bus_o(dut_d), .ext_data_bus_oe_o(d_oe));
    asmp_mem_model MEM (.clk_sys_i(clk), .sel_n_i(ms_n), .addr_i(ea[2:0]), .lane_n_i(be_n),
        .oe_n_i(oe_n), .we_n_i(we_n), .data_i(bus), .stall_i(stall), .ready_o(m_rdy),
        .data_o(mem_d));
    // One access; records pins while its strobe is low
    task automatic acc(input logic w, input logic [24:0] a, input logic [1:0] b,
                       input logic [15:0] d);
        int n;
        wr = w; addr = a; bsel = b; wd = d;
        cnt = 0; oe_bad = 0; n = 0;
        while (rdy_o !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        vld = 1;
        @(negedge clk);
        vld = 0;
        n = 0;
        while (rv !== 1'b1 && n < 200)
        begin
            if ((w ? we_n : re_n) === 1'b0)
            begin
                cnt++; lanes_s = be_n; sel_s = ms_n; addr_s = ea;
                if (w ? (d_oe !== 1'b1) : (d_oe !== 1'b0 || oe_n !== 1'b0)) oe_bad = 1;
            end
            @(negedge clk); n++;
        end
        `CHK(rv, 1'b1)
        `CHK(addr_s, a)
        `CHK(sel_s, ~sel)
        `CHK(oe_bad, 1'b0)
    endtask : acc
    task automatic t_words;
        acc(1, 25'h1000003, 2'h3, 16'h1234);
        `CHK(lanes_s, BE_ALL)
        acc(1, 25'h1000003, 2'h2, 16'hab00);
        `CHK(lanes_s, 2'h1)
        acc(1, 25'h1000003, 2'h1, 16'h00cd);
        `CHK(lanes_s, 2'h2)
        acc(0, 25'h1000003, 2'h3, 16'h0000);
        `CHK(rd, 16'habcd)
        `CHK(oe_bad, 1'b0)
        `CHK(cnt > 0, 1'b1)
        $display("test words done");
    endtask : t_words
    task automatic t_selects;
        for (int i = 0; i < 4; i++)
        begin
            sel = 4'h1 << i;
            acc(1, 25'h0000005, 2'h3, 16'h5a00 + 16'(i));
            acc(0, 25'h0000005, 2'h3, 16'h0000);
            `CHK(rd, 16'h5a00 + 16'(i))
        end
        $display("test selects done");
    endtask : t_selects
    task automatic t_stall;
        int c0;
        acc(1, 25'h0000002, 2'h3, 16'h0f0f);
        c0 = cnt;
        `CHK(c0, int'(ACCESS_CYC))
        stall = 8'h0c;
        acc(1, 25'h0000002, 2'h3, 16'hf0f0);
        `CHK(cnt >= 12 && cnt > c0, 1'b1)
        acc(0, 25'h0000002, 2'h3, 16'h0000);
        `CHK(rd, 16'hf0f0)
        stall = 0;
        $display("test stall done");
    endtask : t_stall
    task automatic results;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    initial
    begin
        repeat (20) @(negedge clk);
        rst_n = 1;
        t_words();
        t_selects();
        t_stall();
        results();
    end
    initial
    begin
        #100000;
        num_errors++;
        results();
    end
endmodule : async_static_memory_port_tb
